// ---- core/ict_pkg.sv ----
/*
  Package for the instruction cycle timing sequencer: opcode encodings,
  timing constants and the decode carrier struct.
  Assumes a single 25 MHz bus clock.
*/
package ict_pkg;

  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned CLK_PER_MC     = 4;
  localparam logic [2:0]  MC_ONE         = 3'h1;
  localparam logic [2:0]  MC_TWO         = 3'h2;
  localparam logic [2:0]  MC_THREE       = 3'h3;
  localparam logic [2:0]  MC_FIVE        = 3'h5;
  localparam logic [1:0]  LEN_ONE        = 2'h1;
  localparam logic [1:0]  LEN_TWO        = 2'h2;
  localparam logic [1:0]  LEN_THREE      = 2'h3;

  localparam logic [7:0] OP_NOP          = 8'h00;
  localparam logic [7:0] OP_BREAKPOINT   = 8'hA5;
  localparam logic [7:0] OP_INC_DATA_PTR = 8'hA3;
  localparam logic [7:0] OP_MUL          = 8'hA4;
  localparam logic [7:0] OP_DIV          = 8'h84;
  localparam logic [7:0] OP_CLR_A        = 8'hE4;
  localparam logic [7:0] OP_CPL_A        = 8'hF4;
  localparam logic [7:0] OP_ROT_L        = 8'h23;
  localparam logic [7:0] OP_ROT_LC       = 8'h33;
  localparam logic [7:0] OP_ROT_R        = 8'h03;
  localparam logic [7:0] OP_ROT_RC       = 8'h13;
  localparam logic [7:0] OP_SWAP         = 8'hC4;
  localparam logic [7:0] OP_DA_A         = 8'hD4;
  localparam logic [7:0] OP_LOGIC_AND_DI = 8'h53;
  localparam logic [7:0] OP_LOGIC_OR_DI  = 8'h43;
  localparam logic [7:0] OP_LOGIC_XOR_DI = 8'h63;

  typedef enum logic [1:0] {
    ICT_IDLE  = 2'b00,
    ICT_FETCH = 2'b01,
    ICT_EXEC  = 2'b11,
    ICT_BRK   = 2'b10
  } ict_state_e;

  typedef struct packed {
    logic       known;
    logic       brk;
    logic [1:0] len;
    logic [2:0] mcyc;
  } ict_dec_s;

endpackage

// ---- core/ict_seq.sv ----
/*
  Instruction cycle timing sequencer: decodes each fetched opcode into its
  byte length and machine cycle count and paces execution in machine
  cycles of four bus clocks, stretched by bus wait states.
  Assumes a memory interface unit that fetches bytes on request and flags
  completion with a one-cycle done pulse; its read timing sets fetch length.
*/
`timescale 1ns/1ns
`default_nettype none
module ict_seq
  import ict_pkg::*;
#(
  parameter int unsigned MC_CLOCKS = CLK_PER_MC
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Control
  input  wire logic       i_run,
  // Memory interface unit fetch port
  output logic            o_fetch_req,
  input  wire logic       i_fetch_done,
  input  wire logic [7:0] i_fetch_data,
  // Internal bus wait state
  input  wire logic       i_bus_wait,
  // Status
  output logic [7:0]      o_opcode,
  output logic [2:0]      o_reg_sel,
  output logic [2:0]      o_mcyc_total,
  output logic [1:0]      o_len,
  output logic            o_insn_done,
  output logic            o_breakpoint,
  output logic            o_unknown,
  output logic [15:0]     o_clk_count
);

  // One clock per machine cycle leaves no room for the phase count
  if (MC_CLOCKS < 2 || MC_CLOCKS > 255) begin : g_mc_clocks_range
    $error("MC_CLOCKS out of range");
  end

  function automatic ict_dec_s decode(input logic [7:0] op);
    ict_dec_s d;
    logic [3:0] hi;
    logic [3:0] lo;
    d  = '{known: 1'b1, brk: 1'b0, len: LEN_ONE, mcyc: MC_ONE};
    hi = op[7:4];
    lo = op[3:0];
    if (op == OP_BREAKPOINT) begin
      d.brk = 1'b1;
    end else if (op == OP_INC_DATA_PTR) begin
      d.mcyc = MC_TWO;
    end else if (op == OP_MUL || op == OP_DIV) begin
      d.mcyc = MC_FIVE;
    end else if (op == OP_LOGIC_AND_DI || op == OP_LOGIC_OR_DI ||
                 op == OP_LOGIC_XOR_DI) begin
      d.len  = LEN_THREE;
      d.mcyc = MC_THREE;
    end else if (op == OP_NOP || op == OP_CLR_A || op == OP_CPL_A ||
                 op == OP_ROT_L || op == OP_ROT_LC || op == OP_ROT_R ||
                 op == OP_ROT_RC || op == OP_SWAP || op == OP_DA_A) begin
      d.mcyc = MC_ONE;
    end else if ((hi == 4'h7 && lo[3]) || (hi == 4'hA && lo[3])) begin
      d.len  = LEN_TWO; // Immediate or direct into bank register
      d.mcyc = MC_TWO;
    end else if ((hi <= 4'h6 || hi == 4'hE) && lo[3]) begin
      d.mcyc = MC_ONE;
    end else if (hi == 4'hF && lo[3]) begin
      d.mcyc = MC_ONE;
    end else if ((hi <= 4'h6 || hi == 4'hE) && lo[3:1] == 3'h3) begin
      d.mcyc = MC_ONE;
    end else if (hi <= 4'h1 && lo == 4'h4) begin
      d.mcyc = MC_ONE; // Increment or decrement accumulator
    end else if (((hi >= 4'h2 && hi <= 4'h6) || hi == 4'h7) && lo == 4'h4) begin
      d.len  = LEN_TWO;
      d.mcyc = MC_TWO;
    end else if ((hi <= 4'h6 || hi == 4'hE) && lo == 4'h5) begin
      d.len  = LEN_TWO;
      d.mcyc = MC_TWO;
    end else if (hi >= 4'h4 && hi <= 4'h6 && lo == 4'h2) begin
      d.len  = LEN_TWO; // Logic op into direct from accumulator
      d.mcyc = MC_TWO;
    end else begin
      d.known = 1'b0;
    end
    return d;
  endfunction

  localparam logic [7:0] MC_LAST = 8'(MC_CLOCKS - 1);

  ict_state_e  state_q, state_d;
  ict_dec_s    dec_q;
  logic [7:0]  phase_q;
  logic [2:0]  mc_q;
  logic [1:0]  bytes_q;
  logic [7:0]  opcode_q;
  logic [15:0] clk_cnt_q;
  logic        req_q;
  logic        done_q;
  logic        brk_q;
  logic        unk_q;

  ict_dec_s    dec_w;
  wire logic   first_byte = (bytes_q == 2'h0);
  wire logic   fetch_ok   = req_q && i_fetch_done;
  wire logic   take       = (state_q == ICT_FETCH) && fetch_ok;
  // Phase advances only when the bus is not stalled
  wire logic   tick       = (state_q == ICT_EXEC) && !i_bus_wait;
  wire logic   mc_end     = tick && (phase_q == MC_LAST);
  wire logic   mc_last    = mc_end && (mc_q + 3'h1 == dec_q.mcyc);
  wire logic   more_bytes = (bytes_q < dec_q.len);
  assign dec_w = decode(i_fetch_data);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ICT_IDLE:  if (i_run) state_d = ICT_FETCH;
      ICT_FETCH: begin
        if (fetch_ok && first_byte && dec_w.brk) begin
          state_d = ICT_BRK;
        end else if (fetch_ok) begin
          state_d = ICT_EXEC;
        end
      end
      ICT_EXEC:  if (mc_last) state_d = i_run ? ICT_FETCH : ICT_IDLE;
      ICT_BRK:   if (!i_run) state_d = ICT_IDLE;
      default:   state_d = ICT_IDLE;
    endcase
  end

  // State and fetch handshake
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ICT_IDLE;
      req_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q  <= mc_last;
      req_q   <= (state_d == ICT_FETCH) && !take;
    end
  end

  // Decoded status stands until the next opcode is taken
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opcode_q <= 8'h00;
      dec_q    <= '0;
      unk_q    <= 1'b0;
    end else if (take && first_byte) begin
      opcode_q <= i_fetch_data;
      dec_q    <= dec_w;
      unk_q    <= !dec_w.known;
    end
  end

  // Halt flag drops only once run is released in the halt state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      brk_q <= 1'b0;
    end else if (take && first_byte) begin
      brk_q <= dec_w.brk;
    end else if (state_q == ICT_BRK && !i_run) begin
      brk_q <= 1'b0;
    end
  end

  // Phase stalls on a wait while the clock count runs on, so waits add
  // clocks but never machine cycles
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_q   <= 8'h00;
      mc_q      <= 3'h0;
      clk_cnt_q <= 16'h0000;
    end else if (take && first_byte) begin
      phase_q   <= 8'h00;
      mc_q      <= 3'h0;
      clk_cnt_q <= 16'h0001;
    end else begin
      if (state_q != ICT_IDLE && state_q != ICT_BRK) begin
        clk_cnt_q <= clk_cnt_q + 16'h0001;
      end
      if (tick) begin
        phase_q <= mc_end ? 8'h00 : phase_q + 8'h01;
      end
      if (mc_end) begin
        mc_q <= mc_q + 3'h1;
      end
    end
  end

  // Operand bytes are counted as consumed one per machine cycle; outer
  // logic fetches them, so this count only bounds the instruction length
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bytes_q <= 2'h0;
    end else if (take && first_byte) begin
      bytes_q <= 2'h1;
    end else if (mc_last || (state_q == ICT_BRK && !i_run)) begin
      bytes_q <= 2'h0;
    end else if (mc_end && more_bytes) begin
      bytes_q <= bytes_q + 2'h1;
    end
  end

  assign o_fetch_req  = req_q;
  assign o_opcode     = opcode_q;
  assign o_reg_sel    = opcode_q[2:0];
  assign o_mcyc_total = dec_q.mcyc;
  assign o_len        = dec_q.len;
  assign o_insn_done  = done_q;
  assign o_breakpoint = brk_q;
  assign o_unknown    = unk_q;
  assign o_clk_count  = clk_cnt_q;

endmodule // ict_seq
`default_nettype wire

// ---- bench/ict_mem_model.sv ----
/* Memory-side model that answers opcode fetches after a set read latency.
   Assumes the sequencer holds its request until the done pulse is taken. */
`timescale 1ns/1ns
`default_nettype none
module ict_mem_model (
  // Fetch handshake
  input  wire logic       i_clk,
  input  wire logic       i_req,
  input  wire logic [7:0] i_op,
  input  wire logic [3:0] i_lat,
  output var  logic       o_done = 1'b0,
  output var  logic [7:0] o_data = 8'h00
);
  int cnt = 0;
  // Data flips while idle so a stale byte never passes for a fresh one
  always @(negedge i_clk) begin
    o_done <= 1'b0;
    o_data <= ~o_data;
    if (i_req && !o_done && cnt >= i_lat) begin
      o_done <= 1'b1;
      o_data <= i_op;
      cnt    <= 0;
    end else if (i_req && !o_done) begin
      cnt <= cnt + 1;
    end
  end
endmodule // ict_mem_model
`default_nettype wire

// ---- bench/ict_seq_chk.sv ----
/* Port checker for ict_seq.
   Assumes the default machine cycle of four clocks. */
`timescale 1ns/1ns
`default_nettype none
module ict_seq_chk
  import ict_pkg::*;
#(parameter int unsigned MC_CLOCKS = CLK_PER_MC) (
  // Watched ports
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       o_fetch_req,
  input wire logic       i_fetch_done,
  input wire logic [7:0] i_fetch_data,
  input wire logic       i_bus_wait,
  input wire logic [7:0] o_opcode,
  input wire logic [2:0] o_reg_sel,
  input wire logic [2:0] o_mcyc_total,
  input wire logic [1:0] o_len,
  input wire logic       o_insn_done,
  input wire logic       o_breakpoint
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire       tk = o_fetch_req && i_fetch_done;
  wire [7:0] d  = i_fetch_data;
  a_opcode_reg_sel: assert property (tk |=> o_opcode == $past(d) &&
    o_reg_sel == $past(d[2:0])) else $error("opcode capture");
  a_one_mc_ops: assert property (tk && d inside {8'h00, 8'hE4, 8'hF4, 8'hC4,
    8'h23, 8'h03} |=> o_mcyc_total == MC_ONE && o_len == LEN_ONE) else $error("one cycle op");
  a_store_acc_one: assert property (tk && d[7:3] == 5'h1F |=> o_mcyc_total == MC_ONE)
    else $error("store op");
  a_direct_two_mc: assert property (tk && d inside {8'h24, 8'h25, 8'h44, 8'h45}
    |=> o_mcyc_total == MC_TWO && o_len == LEN_TWO) else $error("direct op");
  a_ptr_inc_two: assert property (tk && d == 8'hA3 |=> o_mcyc_total == MC_TWO)
    else $error("pointer op");
  a_three_byte_op: assert property (tk && d inside {8'h53, 8'h63}
    |=> o_mcyc_total == MC_THREE && o_len == LEN_THREE) else $error("three byte op");
  a_mul_div_five: assert property (tk && d inside {8'hA4, 8'h84}
    |=> o_mcyc_total == MC_FIVE) else $error("mul div op");
  a_brk_halts: assert property (tk && d == 8'hA5
    |-> ##[1:2] o_breakpoint ##1 !o_fetch_req) else $error("breakpoint");
  a_four_clk_mc: assert property (tk && d == 8'h00 ##1 !i_bus_wait [*4] |=> o_insn_done)
    else $error("machine cycle");
  a_wait_stretch: assert property (tk ##1 i_bus_wait [*4] |=> !o_insn_done)
    else $error("wait stretch");
  c_mul: cover property (tk && d == 8'hA4);
  c_brk: cover property (o_breakpoint);
  c_wait_done: cover property (i_bus_wait ##[1:8] o_insn_done);
endmodule // ict_seq_chk
bind ict_seq ict_seq_chk #(.MC_CLOCKS(MC_CLOCKS)) u_ict_seq_chk (.*);
`default_nettype wire

// ---- bench/tb.sv ----
/* Self-checking bench for ict_seq with a fetch-side memory model.
   Assumes a 25 MHz clock and the default machine cycle length. */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ict_pkg::*;
  logic       i_clk = 1'b0, i_arst_n = 1'b0, i_run = 1'b0, i_bus_wait = 1'b0;
  logic [7:0] mem_op = 8'h00, mem_data, o_opcode;
  logic [3:0] mem_lat = 4'h1;
  logic       mem_done, o_fetch_req, o_insn_done, o_breakpoint, o_unknown;
  logic [15:0] o_clk_count;
  logic [2:0] o_reg_sel, o_mcyc_total;
  logic [1:0] o_len;
  int         failures = 0, n_compared = 0, cyc = 0;
  always #20 i_clk = ~i_clk;
  ict_seq u_ict_seq (.*, .i_fetch_done(mem_done), .i_fetch_data(mem_data));
  ict_mem_model u_ict_mem_model (.i_clk, .i_req(o_fetch_req), .i_op(mem_op), .i_lat(mem_lat),
    .o_done(mem_done), .o_data(mem_data));
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // Times one opcode from its take edge to the done pulse, waits held w cycles
  task automatic run_op(input logic [7:0] op, input logic [2:0] mc, input logic [1:0] ln,
                        input int w, input logic unk = 1'b0);
    int n;
    n = 0;
    mem_op = op;
    do @(posedge i_clk); while (!(o_fetch_req === 1'b1 && mem_done === 1'b1) && ++n < 100);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
      i_bus_wait = (n <= w);
    end while (o_insn_done !== 1'b1 && n < 200);
    chk("clocks", 16'(CLK_PER_MC * mc + w + 1), 16'(n));
    chk("clk_count", 16'(CLK_PER_MC * mc + w + 1), o_clk_count);
    chk("mcyc", 16'(mc), 16'(o_mcyc_total));
    chk("len", 16'(ln), 16'(o_len));
    chk("opcode", 16'(op), 16'(o_opcode));
    chk("reg_sel", 16'(op[2:0]), 16'(o_reg_sel));
    chk("unknown", 16'(unk), 16'(o_unknown));
  endtask
  task automatic t_one_mc();
    logic [7:0] ops[20] = '{8'h00, 8'h28, 8'h2F, 8'h3F, 8'h4A, 8'h0C, 8'hE8, 8'hEF,
                            8'hF8, 8'hFF, 8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'hC4,
                            8'h13, 8'hD4, 8'h14, 8'h26};
    foreach (ops[i]) run_op(ops[i], MC_ONE, LEN_ONE, 0);
    run_op(8'h01, MC_ONE, LEN_ONE, 0, 1'b1);
  endtask
  task automatic t_multi();
    run_op(8'h25, MC_TWO, LEN_TWO, 0);
    run_op(8'h44, MC_TWO, LEN_TWO, 0);
    run_op(8'hA3, MC_TWO, LEN_ONE, 0);
    run_op(8'hA4, MC_FIVE, LEN_ONE, 0);
    run_op(8'h84, MC_FIVE, LEN_ONE, 0);
    run_op(8'h53, MC_THREE, LEN_THREE, 0);
    run_op(8'h63, MC_THREE, LEN_THREE, 0);
    run_op(8'h43, MC_THREE, LEN_THREE, 0);
    run_op(8'h35, MC_TWO, LEN_TWO, 0);
    run_op(8'h74, MC_TWO, LEN_TWO, 0);
    run_op(8'h52, MC_TWO, LEN_TWO, 0);
    run_op(8'h7B, MC_TWO, LEN_TWO, 0);
    run_op(8'hAE, MC_TWO, LEN_TWO, 0);
  endtask
  task automatic t_waits();
    mem_lat = 4'h6;
    run_op(8'h00, MC_ONE, LEN_ONE, 4);
    run_op(8'hA4, MC_FIVE, LEN_ONE, 2);
    mem_lat = 4'h1;
  endtask
  task automatic t_brk();
    int n;
    n = 0;
    mem_op = 8'hA5;
    while (o_breakpoint !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    repeat (3) @(negedge i_clk);
    chk("brk", 16'h0001, 16'(o_breakpoint));
    chk("brk_req", 16'h0000, 16'(o_fetch_req));
    i_run = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("brk_clear", 16'h0000, 16'(o_breakpoint));
    i_run = 1'b1;
    run_op(8'hC4, MC_ONE, LEN_ONE, 0);
  endtask
  initial begin
    repeat (12) @(negedge i_clk);
    i_arst_n = 1'b1;
    i_run = 1'b1;
    t_one_mc();
    t_multi();
    t_waits();
    t_brk();
    give_verdict();
  end
  // A hung handshake would otherwise stall the run through every bounded wait
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end
endmodule // tb
`default_nettype wire
